// >>> verilog/tic_consts.svh
// constants of the timer and interrupt controller: offsets, fields, resets, timing
// assumes a 20 MHz aclk and word-aligned AXI4-Lite register access
//
// Summary of operation
// - free-running 12-bit counter ticks every microsecond
// - counter bits 6 and 9 are interrupt taps
// - taps interrupt only on zero-to-one transitions
// - low byte read latches upper four bits
// - high read returns latched bits, never live
// - eleven maskable sources, each with own vector
// - usb reset, taps, endpoints, dac, gpio, i2c
// - endpoint interrupts on host write or sent
// - dac interrupt has per-pin mask
// - gpio interrupt has per-pin mask
// - dac edge polarity programmable per pin
// - gpio edge polarity programmable per port
// - polarity selects rising or falling edge
// - timer low at 0x24, high at 0x25
// - global and endpoint enables read-write
`ifndef TIC_CONSTS_SVH
`define TIC_CONSTS_SVH

`define TIC_NSRC 11
`define TIC_CNT_W 12
`define TIC_TAP_LO 6
`define TIC_TAP_HI 9
`define TIC_NEP 5
`define TIC_NDAC 8
`define TIC_NGP 4
`define TIC_GPW 8

// timing
`define TIC_CLK_HZ 20000000
`define TIC_TICK_HZ 1000000
`define TIC_TICK_CYC (`TIC_CLK_HZ / `TIC_TICK_HZ)

// register indices; byte address is index times four
`define TIC_IDX_GMASK0 8'h04
`define TIC_IDX_GCFG 8'h08
`define TIC_IDX_GIE 8'h20
`define TIC_IDX_EPIE 8'h21
`define TIC_IDX_TLO 8'h24
`define TIC_IDX_THI 8'h25
`define TIC_IDX_DMASK 8'h31
`define TIC_IDX_DPOL 8'h32
`define TIC_IDX_STAT 8'h38
`define TIC_IDX_CLR 8'h39

// global enable fields
`define TIC_GIE_USB 0
`define TIC_GIE_T128 1
`define TIC_GIE_T1024 2
`define TIC_GIE_DAC 3
`define TIC_GIE_GPIO 4
`define TIC_GIE_I2C 5
`define TIC_GIE_W 6

// reset values and responses
`define TIC_RST_GIE 6'h00
`define TIC_RST_EPIE 5'h00
`define TIC_RST_BYTE 8'h00
`define TIC_RST_GCFG 4'h0
`define TIC_RESP_OKAY 2'h0
`define TIC_RESP_SLVERR 2'h2

`endif

// >>> verilog/tic_pkg.sv
// types shared by the timer and interrupt controller
// assumes tic_consts.svh for the numeric constants
`include "tic_consts.svh"

package tic_pkg;

  // status, clear and enable bit order; also the vector number
  typedef enum logic [3:0] {
    TIC_SRC_USB_RESET,
    TIC_SRC_T128,
    TIC_SRC_T1024,
    TIC_SRC_EP0,
    TIC_SRC_EP1,
    TIC_SRC_EP2,
    TIC_SRC_EP3,
    TIC_SRC_EP4,
    TIC_SRC_DAC,
    TIC_SRC_GPIO,
    TIC_SRC_I2C
  } tic_src_t;

  typedef logic [`TIC_NSRC-1:0] tic_irq_vec_t;

endpackage

// >>> verilog/tic_edge.sv
// edge detector with per-bit polarity select
// assumes inputs synchronous to aclk; no output until one sample is held
`timescale 1ns/1ps
`include "tic_consts.svh"

module tic_edge #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  // sampled level and polarity, 1 selects rising
  input wire logic [W-1:0] sig,
  input wire logic [W-1:0] rise_sel,
  // one-cycle hit per bit
  output logic [W-1:0] hit
);

  logic [W-1:0] prev_q, prev_d;
  logic primed_q, primed_d;

  always_comb begin
    prev_d = sig;
    primed_d = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= '0;
      primed_q <= 1'b0;
    end else if (aclk_en) begin
      prev_q <= prev_d;
      primed_q <= primed_d;
    end
  end

  // rising when selected, falling otherwise
  always_comb begin
    hit = '0;
    if (primed_q && aclk_en) begin
      hit = (rise_sel & sig & ~prev_q) | (~rise_sel & ~sig & prev_q);
    end
  end

endmodule

// >>> verilog/tic_top.sv
// timer and vectored interrupt controller with an AXI4-Lite register slave
// assumes event inputs synchronous to aclk; core acknowledges the offered vector
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "tic_consts.svh"

module tic_top #(
  parameter int ADDR_W = 12,
  parameter int TICK_CYC = `TIC_TICK_CYC
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // axi4-lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // axi4-lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // axi4-lite read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // event sources
  input wire logic usb_reset_evt,
  input wire logic [`TIC_NEP-1:0] ep_rx_done,
  input wire logic [`TIC_NEP-1:0] ep_tx_done,
  input wire logic [`TIC_NDAC-1:0] dac_pins,
  input wire logic [`TIC_NGP*`TIC_GPW-1:0] gpio_pins,
  input wire logic i2c_evt,
  // processor core
  output logic irq,
  output logic vec_valid,
  output tic_pkg::tic_src_t vec_id,
  input wire logic vec_ack
);

  localparam int CW = `TIC_CNT_W;
  localparam int NS = `TIC_NSRC;
  localparam int NGP = `TIC_NGP;
  localparam int GPW = `TIC_GPW;
  localparam int NDAC = `TIC_NDAC;
  localparam int NEP = `TIC_NEP;
  localparam int DIV_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;

  // ---------------- bus handshake state
  logic aw_q, aw_d;
  logic w_q, w_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  // ---------------- register and timer state
  logic [`TIC_GIE_W-1:0] gie_q, gie_d;
  logic [NEP-1:0] epie_q, epie_d;
  logic [GPW-1:0] gmask_q [NGP];
  logic [GPW-1:0] gmask_d [NGP];
  logic [NGP-1:0] gcfg_q, gcfg_d;
  logic [NDAC-1:0] dmask_q, dmask_d;
  logic [NDAC-1:0] dpol_q, dpol_d;
  tic_pkg::tic_irq_vec_t stat_q, stat_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [CW-9:0] hold_q, hold_d;

  // ---------------- decode helpers
  logic do_wr, do_rd;
  logic [7:0] wr_idx, rd_idx;
  logic wr_in_map, rd_in_map;
  logic wr_hit, rd_hit;
  logic tlo_read;
  tic_pkg::tic_irq_vec_t src, en, pend, clr;
  logic [1:0] tap_hit;
  logic [NDAC-1:0] dac_hit;
  logic [NGP*GPW-1:0] gp_hit, gp_rise, gp_mask;

  assign s_awready = aclk_en && !aw_q && !bvalid_q;
  assign s_wready = aclk_en && !w_q && !bvalid_q;
  assign s_arready = aclk_en && !rvalid_q;
  assign s_bvalid = bvalid_q;
  assign s_bresp = bresp_q;
  assign s_rvalid = rvalid_q;
  assign s_rdata = rdata_q;
  assign s_rresp = rresp_q;

  assign do_wr = aclk_en && aw_q && w_q && !bvalid_q;
  assign do_rd = s_arvalid && s_arready;
  assign wr_idx = awaddr_q[9:2];
  assign rd_idx = s_araddr[9:2];
  assign wr_in_map = (ADDR_W <= 10) || (awaddr_q >> 10) == '0;
  assign rd_in_map = (ADDR_W <= 10) || (s_araddr >> 10) == '0;
  // low byte read latches the upper bits in the same cycle
  assign tlo_read = do_rd && rd_in_map && rd_idx == `TIC_IDX_TLO;

  // ---------------- edge detection
  // timer taps fire on rising transitions only
  tic_edge #(.W(2)) u_tap_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclk_en(aclk_en),
    .sig({cnt_q[`TIC_TAP_HI], cnt_q[`TIC_TAP_LO]}),
    .rise_sel(2'h3),
    .hit(tap_hit)
  );

  // per-pin dac polarity
  tic_edge #(.W(NDAC)) u_dac_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclk_en(aclk_en),
    .sig(dac_pins),
    .rise_sel(dpol_q),
    .hit(dac_hit)
  );

  // one polarity bit per gpio port spread over its pins
  genvar gp;
  generate
    for (gp = 0; gp < NGP; gp++) begin : g_port
      assign gp_rise[gp*GPW +: GPW] = {GPW{gcfg_q[gp]}};
      assign gp_mask[gp*GPW +: GPW] = gmask_q[gp];
    end
  endgenerate

  tic_edge #(.W(NGP*GPW)) u_gpio_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .aclk_en(aclk_en),
    .sig(gpio_pins),
    .rise_sel(gp_rise),
    .hit(gp_hit)
  );

  // source collection
  always_comb begin
    src = '0;
    src[tic_pkg::TIC_SRC_USB_RESET] = usb_reset_evt;
    src[tic_pkg::TIC_SRC_T128] = tap_hit[0];
    src[tic_pkg::TIC_SRC_T1024] = tap_hit[1];
    // host wrote the buffer or a packet went out
    src[tic_pkg::TIC_SRC_EP0 +: NEP] = ep_rx_done | ep_tx_done;
    src[tic_pkg::TIC_SRC_DAC] = |(dac_hit & dmask_q);
    src[tic_pkg::TIC_SRC_GPIO] = |(gp_hit & gp_mask);
    src[tic_pkg::TIC_SRC_I2C] = i2c_evt;
  end

  // enables, priority and vector
  always_comb begin
    en = '0;
    en[tic_pkg::TIC_SRC_USB_RESET] = gie_q[`TIC_GIE_USB];
    en[tic_pkg::TIC_SRC_T128] = gie_q[`TIC_GIE_T128];
    en[tic_pkg::TIC_SRC_T1024] = gie_q[`TIC_GIE_T1024];
    en[tic_pkg::TIC_SRC_EP0 +: NEP] = epie_q;
    en[tic_pkg::TIC_SRC_DAC] = gie_q[`TIC_GIE_DAC];
    en[tic_pkg::TIC_SRC_GPIO] = gie_q[`TIC_GIE_GPIO];
    en[tic_pkg::TIC_SRC_I2C] = gie_q[`TIC_GIE_I2C];
    pend = stat_q & en;
    vec_id = tic_pkg::TIC_SRC_USB_RESET;
    for (int i = NS - 1; i >= 0; i--) begin
      if (pend[i]) begin
        vec_id = tic_pkg::tic_src_t'(i[3:0]);
      end
    end
  end

  assign irq = |pend;
  assign vec_valid = |pend;

  // timer
  always_comb begin
    div_d = div_q;
    cnt_d = cnt_q;
    hold_d = hold_q;
    if (div_q == DIV_W'(TICK_CYC - 1)) begin
      div_d = '0;
      cnt_d = cnt_q + 1'b1;
    end else begin
      div_d = div_q + 1'b1;
    end
    if (tlo_read) begin
      hold_d = cnt_q[CW-1:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      cnt_q <= '0;
      hold_q <= '0;
    end else if (aclk_en) begin
      div_q <= div_d;
      cnt_q <= cnt_d;
      hold_q <= hold_d;
    end
  end

  // ---------------- register writes and sticky status
  always_comb begin
    gie_d = gie_q;
    epie_d = epie_q;
    gcfg_d = gcfg_q;
    dmask_d = dmask_q;
    dpol_d = dpol_q;
    gmask_d = gmask_q;
    clr = '0;
    wr_hit = 1'b0;
    if (do_wr && wr_in_map) begin
      // enables are read-write
      if (wr_idx == `TIC_IDX_GIE) begin
        wr_hit = 1'b1;
        if (wstrb_q[0]) gie_d = wdata_q[`TIC_GIE_W-1:0];
      end else if (wr_idx == `TIC_IDX_EPIE) begin
        wr_hit = 1'b1;
        if (wstrb_q[0]) epie_d = wdata_q[NEP-1:0];
      end else if (wr_idx == `TIC_IDX_GCFG) begin
        wr_hit = 1'b1;
        if (wstrb_q[0]) gcfg_d = wdata_q[NGP-1:0];
      end else if (wr_idx == `TIC_IDX_DMASK) begin
        wr_hit = 1'b1;
        if (wstrb_q[0]) dmask_d = wdata_q[NDAC-1:0];
      end else if (wr_idx == `TIC_IDX_DPOL) begin
        wr_hit = 1'b1;
        if (wstrb_q[0]) dpol_d = wdata_q[NDAC-1:0];
      end else if (wr_idx == `TIC_IDX_CLR) begin
        wr_hit = 1'b1;
        if (wstrb_q[0]) clr[7:0] = wdata_q[7:0];
        if (wstrb_q[1]) clr[NS-1:8] = wdata_q[NS-1:8];
      end else begin
        for (int p = 0; p < NGP; p++) begin
          if (wr_idx == 8'(`TIC_IDX_GMASK0 + p)) begin
            wr_hit = 1'b1;
            if (wstrb_q[0]) gmask_d[p] = wdata_q[GPW-1:0];
          end
        end
      end
    end
    if (vec_ack && vec_valid) begin
      clr[vec_id] = 1'b1;
    end
    // a new event beats a clear in the same cycle
    stat_d = (stat_q & ~clr) | src;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie_q <= `TIC_RST_GIE;
      epie_q <= `TIC_RST_EPIE;
      gcfg_q <= `TIC_RST_GCFG;
      dmask_q <= `TIC_RST_BYTE;
      dpol_q <= `TIC_RST_BYTE;
      stat_q <= '0;
      for (int p = 0; p < NGP; p++) begin
        gmask_q[p] <= `TIC_RST_BYTE;
      end
    end else if (aclk_en) begin
      gie_q <= gie_d;
      epie_q <= epie_d;
      gcfg_q <= gcfg_d;
      dmask_q <= dmask_d;
      dpol_q <= dpol_d;
      stat_q <= stat_d;
      gmask_q <= gmask_d;
    end
  end

  // ---------------- read data mux
  always_comb begin
    rd_hit = 1'b0;
    rdata_d = rdata_q;
    if (rd_in_map) begin
      rd_hit = 1'b1;
      case (rd_idx)
        `TIC_IDX_GIE: rdata_d = 32'(gie_q);
        `TIC_IDX_EPIE: rdata_d = 32'(epie_q);
        `TIC_IDX_GCFG: rdata_d = 32'(gcfg_q);
        `TIC_IDX_DMASK: rdata_d = 32'(dmask_q);
        `TIC_IDX_DPOL: rdata_d = 32'(dpol_q);
        `TIC_IDX_STAT: rdata_d = 32'(stat_q);
        `TIC_IDX_CLR: rdata_d = 32'h0000_0000;
        // live low byte, latched high nibble
        `TIC_IDX_TLO: rdata_d = 32'(cnt_q[7:0]);
        `TIC_IDX_THI: rdata_d = 32'(hold_q);
        default: begin
          rd_hit = 1'b0;
          rdata_d = 32'h0000_0000;
          for (int p = 0; p < NGP; p++) begin
            if (rd_idx == 8'(`TIC_IDX_GMASK0 + p)) begin
              rd_hit = 1'b1;
              rdata_d = 32'(gmask_q[p]);
            end
          end
        end
      endcase
    end
    if (!rd_hit) begin
      rdata_d = 32'h0000_0000;
    end
    if (!do_rd) begin
      rdata_d = rdata_q;
    end
  end

  // ---------------- axi channel state
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    if (s_awvalid && s_awready) begin
      aw_d = 1'b1;
      awaddr_d = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      w_d = 1'b1;
      wdata_d = s_wdata;
      wstrb_d = s_wstrb;
    end
    if (do_wr) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = wr_hit ? `TIC_RESP_OKAY : `TIC_RESP_SLVERR;
    end else if (bvalid_q && s_bready) begin
      bvalid_d = 1'b0;
    end
    if (do_rd) begin
      rvalid_d = 1'b1;
      rresp_d = rd_hit ? `TIC_RESP_OKAY : `TIC_RESP_SLVERR;
    end else if (rvalid_q && s_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `TIC_RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `TIC_RESP_OKAY;
    end else if (aclk_en) begin
      aw_q <= aw_d;
      w_q <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

endmodule

// >>> tb/tic_chk.sv
// checker: bus handshakes, vector output and reset state at the top ports
// assumes binding into tic_top, one clock domain
`timescale 1ns/1ps

module tic_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclk_en,
  // register bus
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  input wire logic s_rready,
  // core side
  input wire logic irq,
  input wire logic vec_valid,
  input wire tic_pkg::tic_src_t vec_id
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_irq_vec_same: assert property (irq == vec_valid)
    else $error("irq and vector valid differ");
  a_vec_legal: assert property (vec_valid |-> vec_id <= tic_pkg::TIC_SRC_I2C)
    else $error("vector outside source list");
  a_rst_quiet: assert property ($rose(aresetn) |-> !irq && vec_id == 4'h0)
    else $error("interrupt pending out of reset");
  a_rd_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_rvalid && !s_rready
    |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  a_wr_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready
    |=> !s_bvalid ##1 s_bvalid)
    else $error("write answer timing");
  a_bv_hold: assert property (s_bvalid && !s_bready
    |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  a_freeze_ready: assert property (!aclk_en
    |-> !s_awready && !s_wready && !s_arready)
    else $error("ready while frozen");
  a_freeze_hold: assert property (!aclk_en
    |=> $stable(s_rdata) && $stable(irq) && $stable(s_bvalid) && $stable(s_rvalid))
    else $error("state moved while frozen");
endmodule

bind tic_top tic_chk u_chk (.aclk(aclk), .aresetn(aresetn), .aclk_en(aclk_en),
  .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
  .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid),
  .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid), .s_rready(s_rready),
  .irq(irq), .vec_valid(vec_valid), .vec_id(vec_id));

// >>> tb/tic_core_model.sv
// core model: takes offered vectors after a programmable wait
// assumes vec_ack is sampled one edge after it rises
`timescale 1ns/1ps

module tic_core_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control from bench
  input wire logic run,
  input wire logic [3:0] dly,
  // vector port
  input wire logic vec_valid,
  input wire tic_pkg::tic_src_t vec_id,
  output logic vec_ack,
  // record of taken vectors
  output tic_pkg::tic_src_t got_id,
  output int n_ack
);
  logic [3:0] cnt_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 4'h0;
      vec_ack <= 1'b0;
      n_ack <= 0;
      got_id <= tic_pkg::TIC_SRC_USB_RESET;
    end else if (vec_ack || !run || !vec_valid) begin
      cnt_q <= 4'h0;
      vec_ack <= 1'b0;
    end else if (cnt_q >= dly) begin
      // one vector taken per ack pulse
      vec_ack <= 1'b1;
      got_id <= vec_id;
      n_ack <= n_ack + 1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// >>> tb/tb_top.sv
// testbench: registers, timer, taps, vectors and pin edges
// assumes tic_top with a short tick and the core model
`timescale 1ns/1ps
`include "tic_consts.svh"

module tb_top;
  localparam int TK = 2;
  localparam logic [1:0] OK = `TIC_RESP_OKAY;
  localparam logic [1:0] ER = `TIC_RESP_SLVERR;
  logic aclk, aresetn, aclk_en, run, usb_reset_evt, i2c_evt, irq, vec_valid, vec_ack;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  logic [11:0] s_awaddr, s_araddr, c0, c1;
  logic [31:0] s_wdata, s_rdata, gpio_pins, v, w;
  logic [3:0] s_wstrb, dly;
  logic [1:0] s_bresp, s_rresp;
  logic [4:0] ep_rx_done, ep_tx_done;
  logic [7:0] dac_pins;
  tic_pkg::tic_src_t vec_id, got_id;
  int n_ack, n_fail, comparisons, cyc, t0;
  logic [7:0] ri[8] = '{8'h20, 8'h21, 8'h25, 8'h31, 8'h32, 8'h38, 8'h39, 8'h3f};
  logic [3:0] ev[7] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'ha};
  logic [7:0] td[11] = '{8'h02, 8'h03, 8'h02, 8'h06, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02,
    8'h02, 8'h02};
  logic [31:0] tg[11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h8000, 32'h0, 32'h4000,
    32'h1004000, 32'h4000, 32'h4080};
  logic [3:0] tid[11] = '{4'h0, 4'h8, 4'h0, 4'h0, 4'h8, 4'h9, 4'h0, 4'h0, 4'h0, 4'h9, 4'h0};

  tic_top #(.TICK_CYC(TK)) DUT (.aclk(aclk), .aresetn(aresetn), .aclk_en(aclk_en),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .usb_reset_evt(usb_reset_evt), .ep_rx_done(ep_rx_done),
    .ep_tx_done(ep_tx_done), .dac_pins(dac_pins), .gpio_pins(gpio_pins), .i2c_evt(i2c_evt),
    .irq(irq), .vec_valid(vec_valid), .vec_id(vec_id), .vec_ack(vec_ack));
  tic_core_model core (.aclk(aclk), .aresetn(aresetn), .run(run), .dly(dly),
    .vec_valid(vec_valid), .vec_id(vec_id), .vec_ack(vec_ack), .got_id(got_id), .n_ack(n_ack));

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_awaddr <= {2'h0, i, 2'h0};
    s_wdata <= d;
    s_wstrb <= 4'hf;
    {s_awvalid, s_wvalid, s_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_bresp));
  endtask

  task rd(input logic [7:0] i, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    s_araddr <= {2'h0, i, 2'h0};
    {s_arvalid, s_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    s_rready <= 1'b0;
    d = s_rdata;
    chk("rresp", 32'(er), 32'(s_rresp));
  endtask

  task wait_irq;
    for (int k = 0; k < 5000 && irq !== 1'b1; k++) @(posedge aclk);
  endtask

  task tap(input logic [31:0] ge, input int per, input logic [3:0] id);
    wr(8'h20, ge, OK);
    wr(8'h39, 32'h7ff, OK);
    wait_irq;
    wr(8'h39, 32'h7ff, OK);
    wait_irq;
    t0 = cyc;
    wr(8'h39, 32'h7ff, OK);
    wait_irq;
    chk("tap period", per, cyc - t0);
    chk("tap vector", 32'(id), 32'(vec_id));
  endtask

  initial begin
    {aresetn, run, usb_reset_evt, i2c_evt, s_awvalid, s_wvalid, s_bready} = '0;
    {s_arvalid, s_rready, ep_rx_done, ep_tx_done, dac_pins, gpio_pins, dly} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
    aclk_en = 1'b1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ri[k]) begin
      rd(ri[k], (k == 7) ? ER : OK, v);
      chk("reset value", 32'h0, v);
    end
    wr(8'h24, 32'h0, ER);
    wr(8'h25, 32'h0, ER);
    wr(8'h20, 32'hffffffff, OK);
    rd(8'h20, OK, v);
    chk("global enable", 32'h3f, v);
    wr(8'h21, 32'hffffffff, OK);
    rd(8'h21, OK, v);
    chk("endpoint enable", 32'h1f, v);
    wr(8'h20, 32'h0, OK);
    aclk_en <= 1'b0;
    repeat (4) @(posedge aclk);
    aclk_en <= 1'b1;
    $display("test registers done");
    rd(8'h24, OK, v);
    t0 = cyc;
    rd(8'h25, OK, w);
    c0 = {w[3:0], v[7:0]};
    repeat (3) begin
      repeat (3000) @(posedge aclk);
      rd(8'h25, OK, v);
      chk("held nibble", w, v);
      rd(8'h24, OK, v);
      c1 = 12'((cyc - t0) / TK);
      t0 = cyc;
      rd(8'h25, OK, w);
      v = {w[3:0], v[7:0]} - c0;
      chk("elapsed", c1, (v[11:0] == c1 + 12'h1) ? c1 : v[11:0]);
      c0 = c0 + v[11:0];
    end
    $display("test timer done");
    tap(32'h2, 128 * TK, 4'h1);
    tap(32'h4, 1024 * TK, 4'h2);
    wr(8'h20, 32'h0, OK);
    repeat (300) @(posedge aclk);
    chk("masked irq", 32'h0, 32'(irq));
    rd(8'h38, OK, v);
    chk("raw status", 32'h1, 32'(v[1]));
    $display("test taps done");
    wr(8'h20, 32'h39, OK);
    wr(8'h21, 32'h1f, OK);
    wr(8'h39, 32'h7ff, OK);
    // usb reset, i2c, rx on ep0-2, tx on ep1 ep3 ep4
    {usb_reset_evt, i2c_evt, ep_rx_done, ep_tx_done} <= 12'hcfa;
    @(posedge aclk);
    {usb_reset_evt, i2c_evt, ep_rx_done, ep_tx_done} <= 12'h0;
    repeat (2) @(posedge aclk);
    run <= 1'b1;
    foreach (ev[k]) begin
      for (int j = 0; j < 50 && n_ack <= k; j++) @(posedge aclk);
      chk("vector order", 32'(ev[k]), 32'(got_id));
    end
    repeat (3) @(posedge aclk);
    chk("all taken", 32'h0, 32'(irq));
    run <= 1'b0;
    dly <= 4'h3;
    $display("test vectors done");
    wr(8'h31, 32'h05, OK);
    wr(8'h32, 32'h01, OK);
    wr(8'h05, 32'h80, OK);
    wr(8'h07, 32'h01, OK);
    wr(8'h08, 32'h2, OK);
    wr(8'h20, 32'h18, OK);
    foreach (td[k]) begin
      dac_pins <= td[k];
      gpio_pins <= tg[k];
      repeat (3) @(posedge aclk);
      chk("pin irq", 32'(tid[k] != 4'h0), 32'(irq));
      if (tid[k] != 4'h0) begin
        t0 = n_ack;
        run <= 1'b1;
        for (int j = 0; j < 50 && n_ack == t0; j++) @(posedge aclk);
        run <= 1'b0;
        chk("pin vector", 32'(tid[k]), 32'(got_id));
      end
    end
    $display("test pins done");
    conclude;
  end

  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    $display("watchdog expired");
    conclude;
  end
endmodule
